// ==== design/scan_pin_share.sv ====
// Scan port pin sharing: mode fuse, scan state machine, user pad control
//
// Design decisions made here: register access over Wishbone and the register addresses.
`default_nettype none

// What this block does
// - Fuse blown selects dedicated test mode, fuse unprogrammed selects flexible mode.
// - Dedicated mode never hands TCK, TDI, TDO to user logic.
// - Dedicated mode handles TMS exactly as the standard scan state machine.
// - TMS and TDI pull-ups on in dedicated mode, off in flexible mode.
// - Flexible mode takes the shared pins for scan on TCK rise with TMS low.
// - Shared pins stay in scan function until test-logic-reset, then return.
// - Five TCK rises with TMS high reach test-logic-reset from any state.
// - Reserved scan reset pin is an active-low scan reset with pull-up.
// - Unreserved scan reset pin is user I/O with pull-up off.
// - All pads stay high impedance until power is good.
// - Each pad is set up as input, output, tristate or bidirectional.
module scan_pin_share
  import scan_pins_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Straps and power
  input wire logic fuse_blown_i,
  input wire logic pwr_ok_i,
  // Pads
  input wire logic tms_i,
  input wire logic [NPAD-1:0] pad_i,
  output logic [NPAD-1:0] pad_o,
  output logic [NPAD-1:0] pad_oe_o,
  // Pull-up enables
  output logic tms_pu_o,
  output logic tdi_pu_o,
  output logic trst_pu_o
);

  // ********************
  // Input synchronisers
  // ********************
  logic [NPAD-1:0] pad_s1_r, pad_s2_r;
  logic [2:0] misc_s1_r, misc_s2_r;
  logic tck_d_r, tms_s, fuse_s, pwr_s, tck_rise, tck_fall;

  always_ff @(posedge clk_i) begin
    pad_s1_r <= pad_i;
    pad_s2_r <= pad_s1_r;
    misc_s1_r <= {pwr_ok_i, fuse_blown_i, tms_i};
    misc_s2_r <= misc_s1_r;
    tck_d_r <= pad_s2_r[PAD_TCK];
  end

  assign {pwr_s, fuse_s, tms_s} = misc_s2_r;
  assign tck_rise = pad_s2_r[PAD_TCK] & ~tck_d_r;
  assign tck_fall = ~pad_s2_r[PAD_TCK] & tck_d_r;

  // ********************
  // Fuse capture
  // ********************
  // The fuse is read once, after the synchroniser has filled, then frozen
  logic [1:0] fuse_cnt_r;
  logic fuse_done_r, dedicated_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_cnt_r <= 2'h0;
      fuse_done_r <= 1'b0;
      dedicated_r <= 1'b0;
    end else if (!fuse_done_r) begin
      fuse_cnt_r <= fuse_cnt_r + 2'h1;
      if (fuse_cnt_r == FUSE_SETTLE) begin
        fuse_done_r <= 1'b1;
        dedicated_r <= fuse_s;
      end
    end
  end

  AST_FUSE_FROZEN: assert property (@(posedge clk_i) disable iff (rst_i)
    fuse_done_r |=> $stable(dedicated_r) && fuse_done_r)
    else $error("Mode changed after fuse capture");

  // ********************
  // Registers
  // ********************
  logic reserve_r, ack_r, req, wr;
  logic [15:0] cfg_r;
  logic [7:0] out_r, oen_r;
  logic [31:0] dat_r;
  assign req = cyc_i & stb_i & ~ack_r;
  assign wr = req & we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reserve_r <= CTRL_RESERVE_RST;
      cfg_r <= CFG_RST;
      out_r <= OUT_RST;
      oen_r <= OEN_RST;
    end else if (wr) begin
      if (adr_i == ADR_CTRL && sel_i[0]) begin
        reserve_r <= dat_i[CTRL_RESERVE_TRST];
      end
      if (adr_i == ADR_CFG && sel_i[0]) begin
        cfg_r[7:0] <= dat_i[7:0];
      end
      if (adr_i == ADR_CFG && sel_i[1]) begin
        cfg_r[15:8] <= dat_i[15:8];
      end
      if (adr_i == ADR_OUT && sel_i[0]) begin
        out_r <= dat_i[7:0];
      end
      if (adr_i == ADR_OEN && sel_i[0]) begin
        oen_r <= dat_i[7:0];
      end
    end
  end

  // ********************
  // Scan state machine
  // ********************
  tap_state_t tap_r, tap_nxt;
  logic trst_s;
  assign trst_s = reserve_r & ~pad_s2_r[PAD_TRST];

  function automatic tap_state_t tap_step(input tap_state_t s, input logic m);
    tap_state_t n;
    n = s;
    unique case (s)
      TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: n = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: n = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: n = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: n = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: n = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: n = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: n = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: n = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
    endcase
    return n;
  endfunction

  always_comb begin
    tap_nxt = tap_r;
    if (trst_s) begin
      tap_nxt = TAP_RESET;
    end else if (tck_rise) begin
      tap_nxt = tap_step(tap_r, tms_s);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_r <= TAP_RESET;
    end else begin
      tap_r <= tap_nxt;
    end
  end

  // Shift path: instruction register and one-bit bypass
  logic [IR_LEN-1:0] ir_sh_r;
  logic bypass_r, tdo_bit_r, tdo_en_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_sh_r <= IR_CAPTURE;
      bypass_r <= 1'b0;
    end else if (tck_rise) begin
      if (tap_r == TAP_CAP_IR) begin
        ir_sh_r <= IR_CAPTURE;
      end else if (tap_r == TAP_SHIFT_IR) begin
        ir_sh_r <= {pad_s2_r[PAD_TDI], ir_sh_r[IR_LEN-1:1]};
      end
      if (tap_r == TAP_CAP_DR) begin
        bypass_r <= 1'b0;
      end else if (tap_r == TAP_SHIFT_DR) begin
        bypass_r <= pad_s2_r[PAD_TDI];
      end
    end
  end

  // Data out changes on the falling edge so the tester samples it stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_bit_r <= 1'b0;
      tdo_en_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_en_r <= (tap_r == TAP_SHIFT_IR) || (tap_r == TAP_SHIFT_DR);
      tdo_bit_r <= (tap_r == TAP_SHIFT_IR) ? ir_sh_r[0] : bypass_r;
    end
  end

  // Counts consecutive TCK rises with TMS high, for checking only
  logic [2:0] hi_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_cnt_r <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s) begin
        hi_cnt_r <= 3'h0;
      end else if (hi_cnt_r != TLR_TMS_HIGH_CYCLES) begin
        hi_cnt_r <= hi_cnt_r + 3'h1;
      end
    end
  end

  AST_FIVE_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    hi_cnt_r == TLR_TMS_HIGH_CYCLES |-> tap_r == TAP_RESET)
    else $error("Five TMS-high clocks did not reach reset state");

  AST_SCAN_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    (reserve_r && !pad_s2_r[PAD_TRST]) |=> tap_r == TAP_RESET)
    else $error("Scan reset pin did not reset the state machine");

  // ********************
  // Pin ownership
  // ********************
  logic scan_active_r, scan_own;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_active_r <= 1'b0;
    end else if (!dedicated_r && tck_rise && !tms_s) begin
      scan_active_r <= 1'b1;
    end else if (tap_r == TAP_RESET) begin
      scan_active_r <= 1'b0;
    end
  end

  assign scan_own = dedicated_r | scan_active_r;

  AST_FLEX_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
    (!dedicated_r && tck_rise && !tms_s) |=> scan_active_r ##1 scan_own)
    else $error("Flexible mode did not take the pins on entry");

  AST_FLEX_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
    (tap_r == TAP_RESET && !(tck_rise && !tms_s)) |=> !scan_active_r)
    else $error("Pins not released at reset state");

  AST_FLEX_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (scan_active_r && tap_r != TAP_RESET) |=> scan_active_r)
    else $error("Pins released outside reset state");

  // ********************
  // Pad drive
  // ********************
  logic [NPAD-1:0] pad_nxt, oe_nxt, in_vis;

  always_comb begin
    for (int i = 0; i < NPAD; i++) begin
      pad_nxt[i] = out_r[i];
      in_vis[i] = 1'b0;
      unique case (pio_mode_t'(cfg_r[2*i +: 2]))
        PIO_IN: begin
          oe_nxt[i] = 1'b0;
          in_vis[i] = 1'b1;
        end
        PIO_OUT: oe_nxt[i] = 1'b1;
        PIO_TRI: oe_nxt[i] = oen_r[i];
        PIO_BIDIR: begin
          oe_nxt[i] = oen_r[i];
          in_vis[i] = 1'b1;
        end
      endcase
    end
    if (scan_own) begin
      oe_nxt[PAD_TCK] = 1'b0;
      oe_nxt[PAD_TDI] = 1'b0;
      oe_nxt[PAD_TDO] = tdo_en_r;
      pad_nxt[PAD_TCK] = 1'b0;
      pad_nxt[PAD_TDI] = 1'b0;
      pad_nxt[PAD_TDO] = tdo_bit_r;
      in_vis[PAD_TDO:PAD_TCK] = 3'b000;
    end
    if (reserve_r) begin
      oe_nxt[PAD_TRST] = 1'b0;
      pad_nxt[PAD_TRST] = 1'b0;
      in_vis[PAD_TRST] = 1'b0;
    end
    if (!pwr_s) begin
      oe_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= '0;
      pad_oe_o <= '0;
      tms_pu_o <= 1'b0;
      tdi_pu_o <= 1'b0;
      trst_pu_o <= CTRL_RESERVE_RST;
    end else begin
      pad_o <= pad_nxt;
      pad_oe_o <= oe_nxt;
      tms_pu_o <= dedicated_r;
      tdi_pu_o <= dedicated_r;
      trst_pu_o <= reserve_r;
    end
  end

  AST_DEDICATED_PINS: assert property (@(posedge clk_i) disable iff (rst_i)
    dedicated_r |=> !pad_oe_o[PAD_TCK] && !pad_oe_o[PAD_TDI] && pad_o[PAD_TDO] == $past(tdo_bit_r))
    else $error("Dedicated scan pin handed to user logic");

  AST_PULLUPS: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 tms_pu_o == $past(dedicated_r) && tdi_pu_o == tms_pu_o)
    else $error("TMS or TDI pull-up does not follow the mode");

  AST_TRST_PULLUP: assert property (@(posedge clk_i) disable iff (rst_i)
    !reserve_r |=> !trst_pu_o)
    else $error("Pull-up left on an unreserved reset pin");

  AST_POWER_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwr_s |=> pad_oe_o == '0)
    else $error("Pad driven before power is good");

  AST_PIO_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwr_s && cfg_r[NPAD+1:NPAD] == PIO_OUT) |=>
      pad_oe_o[NPAD/2] && pad_o[NPAD/2] == $past(out_r[NPAD/2]))
    else $error("Output-mode pad not driven");

  // ********************
  // Bus answer
  // ********************
  status_t status;
  assign status = '{tap: tap_r, pwr_ok: pwr_s, scan_active: scan_active_r,
                    dedicated: dedicated_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req;
      dat_r <= '0;
      if (req && !we_i) begin
        unique case (adr_i)
          ADR_CTRL: dat_r <= {31'h0, reserve_r};
          ADR_STATUS: dat_r <= {25'h0, status};
          ADR_CFG: dat_r <= {16'h0, cfg_r};
          ADR_OUT: dat_r <= {24'h0, out_r};
          ADR_OEN: dat_r <= {24'h0, oen_r};
          ADR_IN: dat_r <= {24'h0, pad_s2_r & in_vis};
          default: dat_r <= '0;
        endcase
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

endmodule
`default_nettype wire

// ==== design/scan_pins_pkg.sv ====
// Constants and types for the scan port pin sharing block
`default_nettype none
package scan_pins_pkg;

  // ********************
  // Pads
  // ********************
  localparam int NPAD = 8;
  localparam int PAD_TCK = 0;
  localparam int PAD_TDI = 1;
  localparam int PAD_TDO = 2;
  localparam int PAD_TRST = 3;

  // ********************
  // Register map (byte addresses)
  // ********************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_CFG = 8'h08;
  localparam logic [7:0] ADR_OUT = 8'h0c;
  localparam logic [7:0] ADR_OEN = 8'h10;
  localparam logic [7:0] ADR_IN = 8'h14;

  localparam int CTRL_RESERVE_TRST = 0;
  localparam logic CTRL_RESERVE_RST = 1'b1;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] OEN_RST = 8'h00;

  // ********************
  // Scan logic
  // ********************
  localparam int IR_LEN = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [2:0] TLR_TMS_HIGH_CYCLES = 3'h5;
  localparam logic [1:0] FUSE_SETTLE = 2'h3;

  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000,
    TAP_IDLE = 4'b0001,
    TAP_SEL_DR = 4'b0010,
    TAP_CAP_DR = 4'b0011,
    TAP_SHIFT_DR = 4'b0100,
    TAP_EXIT1_DR = 4'b0101,
    TAP_PAUSE_DR = 4'b0110,
    TAP_EXIT2_DR = 4'b0111,
    TAP_UPD_DR = 4'b1000,
    TAP_SEL_IR = 4'b1001,
    TAP_CAP_IR = 4'b1010,
    TAP_SHIFT_IR = 4'b1011,
    TAP_EXIT1_IR = 4'b1100,
    TAP_PAUSE_IR = 4'b1101,
    TAP_EXIT2_IR = 4'b1110,
    TAP_UPD_IR = 4'b1111
  } tap_state_t;

  typedef enum logic [1:0] {
    PIO_IN = 2'b00,
    PIO_OUT = 2'b01,
    PIO_TRI = 2'b10,
    PIO_BIDIR = 2'b11
  } pio_mode_t;

  typedef struct packed {
    logic [3:0] tap;
    logic pwr_ok;
    logic scan_active;
    logic dedicated;
  } status_t;

endpackage
`default_nettype wire

// ==== test/scan_ctl_model.sv ====
// Behavioural external scan test controller driving the shared scan pins
`default_nettype none
module scan_ctl_model (
  // Scan pins
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  output var logic trst_n_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] tdo_seen;

  initial begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
    tdo_seen = 16'h0000;
  end

  // ********************
  // One frame of n clocks, 320 ns each
  // ********************
  // Starts 13 ns after the caller's clock edge so link edges never meet the system edge
  task automatic frame(input int n, input logic [15:0] tms_v, input logic [15:0] tdi_v);
    #13;
    for (int k = 0; k < n; k++) begin
      tck_o = 1'b0;
      tms_o = tms_v[k];
      tdi_o = tdi_v[k];
      #160;
      tck_o = 1'b1;
      #160;
      // Late sampling: the device resynchronises the link, so its output lags the edge
      tdo_seen[k] = tdo_oe_i & tdo_i;
    end
    // Clock stands high and TMS returns high while no test is wanted
    tms_o = 1'b1;
    tdi_o = ~tdi_o;
  endtask

  task automatic set_trst(input logic v);
    trst_n_o = v;
  endtask
endmodule
`default_nettype wire

// ==== test/scan_pin_share_tb.sv ====
// Self-checking bench for the scan port pin sharing block
`default_nettype none
module scan_pin_share_tb
  import scan_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, fuse_blown_i, pwr_ok_i;
  logic tms_pu_o, tdi_pu_o, trst_pu_o;
  logic [7:0] adr_i, pad_i, pad_o, pad_oe_o, ext_r;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rnd, seed, mk;
  wire logic tck, tms, tdi, trst_n;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  assign pad_i = (pad_oe_o & pad_o) | (~pad_oe_o & {ext_r[7:4], trst_n, ext_r[2], tdi, tck});

  scan_pin_share u_scan_pin_share (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .fuse_blown_i(fuse_blown_i), .pwr_ok_i(pwr_ok_i), .tms_i(tms), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_o(pad_oe_o), .tms_pu_o(tms_pu_o), .tdi_pu_o(tdi_pu_o),
    .trst_pu_o(trst_pu_o));

  scan_ctl_model u_scan_ctl_model (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .tdo_i(pad_o[PAD_TDO]), .tdo_oe_i(pad_oe_o[PAD_TDO]));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ********************
  // Checking helpers
  // ********************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] st(input logic d, input logic a, input tap_state_t t);
    st = {25'h0, status_t'{t, 1'b1, a, d}};
  endfunction

  // Read data is taken at the edge that samples ack high
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      mk = msk_q.pop_front();
      chk("rdata", exp_q.pop_front(), dat_o & mk);
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic do_reset(input logic fuse);
    fuse_blown_i <= fuse;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(4000 * 40);
    errors++;
    $display("BAD watchdog expected done seen hang");
    test_done;
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    seed = 32'h7520894b;
    rnd = $random(seed);
    ext_r = rnd[7:0];
    {rst_i, cyc_i, stb_i, we_i} = 4'b1000;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    fuse_blown_i = 1'b0;
    pwr_ok_i = 1'b1;
    do_reset(1'b0);
    chk("pu", 32'h1, {29'h0, tms_pu_o, tdi_pu_o, trst_pu_o});
    wb(1'b0, ADR_CTRL, 32'h1, 32'h1);
    wb(1'b0, ADR_STATUS, st(1'b0, 1'b0, TAP_RESET), 32'h7f);
    wb(1'b0, 8'h40, 32'h0, 32'hffffffff);
    $display("test defaults done");
    rnd = $random(seed);
    wb(1'b1, ADR_CFG, 32'h3914, 32'h0);
    wb(1'b1, ADR_OUT, rnd, 32'h0);
    wb(1'b1, ADR_OEN, 32'h20, 32'h0);
    wb(1'b0, ADR_IN, {24'h0, ext_r[7:6], 6'b000001}, 32'hff);
    chk("oe", 32'h36, {24'h0, pad_oe_o});
    chk("out", rnd & 32'h36, {24'h0, pad_o & 8'h36});
    pwr_ok_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("oe", 32'h0, {24'h0, pad_oe_o});
    pwr_ok_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("oe", 32'h36, {24'h0, pad_oe_o});
    $display("test pad modes done");
    @(posedge clk_i);
    u_scan_ctl_model.frame(5, 16'b00110, 16'h0);
    repeat (6) @(posedge clk_i);
    chk("oe", 32'h0, {30'h0, pad_oe_o[1:0]});
    wb(1'b0, ADR_STATUS, st(1'b0, 1'b1, TAP_SHIFT_IR), 32'h7f);
    u_scan_ctl_model.frame(3, 16'h0, 16'h5);
    chk("tdo", 32'h1, {29'h0, u_scan_ctl_model.tdo_seen[2:0]});
    u_scan_ctl_model.frame(4, 16'hf, 16'h0);
    repeat (6) @(posedge clk_i);
    chk("oe", 32'h0, {30'h0, pad_oe_o[1:0]});
    wb(1'b0, ADR_STATUS, st(1'b0, 1'b1, TAP_SEL_IR), 32'h7f);
    u_scan_ctl_model.frame(1, 16'h1, 16'h0);
    repeat (8) @(posedge clk_i);
    chk("oe", 32'h36, {24'h0, pad_oe_o});
    wb(1'b0, ADR_STATUS, st(1'b0, 1'b0, TAP_RESET), 32'h7f);
    $display("test flexible done");
    do_reset(1'b1);
    chk("pu", 32'h7, {29'h0, tms_pu_o, tdi_pu_o, trst_pu_o});
    wb(1'b1, ADR_CFG, 32'h0014, 32'h0);
    chk("oe", 32'h0, {29'h0, pad_oe_o[2:0]});
    wb(1'b0, ADR_STATUS, st(1'b1, 1'b0, TAP_RESET), 32'h7d);
    @(posedge clk_i);
    u_scan_ctl_model.frame(3, 16'b110, 16'h0);
    repeat (6) @(posedge clk_i);
    wb(1'b0, ADR_STATUS, st(1'b1, 1'b0, TAP_SEL_IR), 32'h78);
    u_scan_ctl_model.set_trst(1'b0);
    repeat (6) @(posedge clk_i);
    wb(1'b0, ADR_STATUS, st(1'b1, 1'b0, TAP_RESET), 32'h78);
    u_scan_ctl_model.set_trst(1'b1);
    wb(1'b1, ADR_CTRL, 32'h0, 32'h0);
    chk("pu", 32'h6, {29'h0, tms_pu_o, tdi_pu_o, trst_pu_o});
    wb(1'b0, ADR_IN, {24'h0, ext_r[7:4], 4'b1000}, 32'hff);
    $display("test dedicated done");
    test_done;
  end
endmodule
`default_nettype wire
